// ===== logic/pssf_flags.sv
// Special status and clock flag bank with its register port.
`timescale 1ns/1ps
module pssf_flags
   import pssf_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int H10MS = HALF_10MS_MS,
   parameter int H100MS = HALF_100MS_MS,
   parameter int H1S = HALF_1S_MS,
   parameter int H1MIN = HALF_1MIN_MS,
   parameter int UNITS = 8
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic run_switch_i,
   input wire logic scan_end_i,
   input wire logic param_error_flag_i,
   input wire logic syntax_error_flag_i,
   input wire logic circuit_error_flag_i,
   input wire logic operation_error_flag_i,
   input wire logic [15:0] battery_level_i,
   input wire logic power_ok_i,
   input wire logic [UNITS-1:0] supply_fail_i,
   input wire logic arith_valid_i,
   input wire logic [1:0] arith_op_i,
   input wire logic [15:0] arith_a_i,
   input wire logic [15:0] arith_b_i,
   input wire logic instr_start_i,
   input wire logic instr_done_i,
   input wire logic xfer_active_i,
   input wire logic irq_pending_i,
   output logic irq_service_o,
   output logic run_monitor_no_o,
   output logic run_monitor_nc_o,
   output logic initial_pulse_no_o,
   output logic initial_pulse_nc_o,
   output logic error_summary_flag_o,
   output logic pulse_10ms_o,
   output logic pulse_100ms_o,
   output logic pulse_1s_o,
   output logic pulse_1min_o,
   output logic [15:0] arith_result_o
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Lowest failing unit wins when several drop together.
   function automatic logic [15:0] lowest_set(input logic [UNITS-1:0] v);
      logic [15:0] idx;
      idx = '0;
      for (int i = UNITS - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 16'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic sel(input logic [3:0] a, input logic [3:0] r);
      return a == r;
   endfunction

   localparam int TCW = $clog2(TICK_CYC + 1);
   localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYC - 1);

   // ****************************************************************
   // Millisecond time base
   // ****************************************************************
   logic [TCW-1:0] tick_count;
   logic ms_tick;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_count <= '0;
         ms_tick <= 1'b0;
      end else if (tick_count == TICK_LAST) begin
         tick_count <= '0;
         ms_tick <= 1'b1;
      end else begin
         tick_count <= tick_count + 1'b1;
         ms_tick <= 1'b0;
      end
   end

   // ****************************************************************
   // Clock pulse flags
   // ****************************************************************
   pssf_pulse_gen #(.HALF_TICKS(H10MS)) u_p10ms (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .tick_i(ms_tick),
      .pulse_o(pulse_10ms_o)
   );
   pssf_pulse_gen #(.HALF_TICKS(H100MS)) u_p100ms (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .tick_i(ms_tick),
      .pulse_o(pulse_100ms_o)
   );
   pssf_pulse_gen #(.HALF_TICKS(H1S)) u_p1s (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .tick_i(ms_tick),
      .pulse_o(pulse_1s_o)
   );
   pssf_pulse_gen #(.HALF_TICKS(H1MIN)) u_p1min (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .tick_i(ms_tick),
      .pulse_o(pulse_1min_o)
   );

   // ****************************************************************
   // Register write decode
   // ****************************************************************
   logic wr_ctrl;
   logic wr_clear;
   logic [15:0] battery_threshold_reg;
   logic [15:0] outage_allow_time_reg;
   logic [15:0] supply_loss_unit_reg;

   assign wr_ctrl = wr_i && sel(addr_i, REG_CTRL);
   assign wr_clear = wr_i && sel(addr_i, REG_CLEAR);

   // Status, loss unit and result words have no write path at all.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         battery_threshold_reg <= RST_BATT_THR;
         outage_allow_time_reg <= RST_OUTAGE_ALLOW;
      end else if (wr_i) begin
         if (sel(addr_i, REG_BATT_THR)) begin
            battery_threshold_reg <= wdata_i;
         end
         if (sel(addr_i, REG_OUTAGE_ALLOW)) begin
            outage_allow_time_reg <= wdata_i;
         end
      end
   end

   // ****************************************************************
   // Power supervision
   // ****************************************************************
   logic [15:0] outage_ms;
   logic outage_long;
   logic fault_stop;
   logic momentary_outage_flag;
   logic power_fail_detected_flag;
   logic power_was_ok;
   logic outage_start;

   assign outage_start = power_was_ok && !power_ok_i;
   assign outage_long = !power_ok_i && (outage_ms > outage_allow_time_reg);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         power_was_ok <= 1'b1;
         outage_ms <= '0;
      end else begin
         power_was_ok <= power_ok_i;
         if (power_ok_i) begin
            outage_ms <= '0;
         end else if (ms_tick && outage_ms != 16'hffff) begin
            outage_ms <= outage_ms + 16'h0001;
         end
      end
   end

   // A short outage only flags; execution carries on.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         momentary_outage_flag <= 1'b0;
      end else if (outage_start) begin
         momentary_outage_flag <= 1'b1;
      end else if (wr_clear && wdata_i[CL_MOMENTARY]) begin
         momentary_outage_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         power_fail_detected_flag <= 1'b0;
      end else if (outage_long) begin
         power_fail_detected_flag <= 1'b0;
      end else if (outage_start) begin
         power_fail_detected_flag <= 1'b1;
      end else if (wr_clear && wdata_i[CL_PF_DET]) begin
         power_fail_detected_flag <= 1'b0;
      end
   end

   // A long outage forces stop until the run switch is cycled.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fault_stop <= 1'b0;
      end else if (outage_long) begin
         fault_stop <= 1'b1;
      end else if (!run_switch_i) begin
         fault_stop <= 1'b0;
      end
   end

   // ****************************************************************
   // Run mode and scan tracking
   // ****************************************************************
   pssf_mode_t mode;
   pssf_mode_t next_mode;
   logic run_req;
   logic to_stop;

   assign run_req = run_switch_i && !fault_stop && !outage_long;
   assign to_stop = (mode != PSSF_STOP) && !run_req;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         PSSF_STOP: begin
            if (run_req) begin
               next_mode = PSSF_FIRST_SCAN;
            end
         end
         PSSF_FIRST_SCAN: begin
            if (!run_req) begin
               next_mode = PSSF_STOP;
            end else if (scan_end_i) begin
               next_mode = PSSF_RUN;
            end
         end
         PSSF_RUN: begin
            if (!run_req) begin
               next_mode = PSSF_STOP;
            end
         end
         default: begin
            next_mode = PSSF_STOP;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode <= PSSF_STOP;
      end else begin
         mode <= next_mode;
      end
   end

   assign run_monitor_no_o = (mode != PSSF_STOP);
   assign run_monitor_nc_o = ~run_monitor_no_o;
   assign initial_pulse_no_o = (mode == PSSF_FIRST_SCAN);
   assign initial_pulse_nc_o = ~initial_pulse_no_o;

   // ****************************************************************
   // Error, battery and supply flags
   // ****************************************************************
   logic battery_low_flag;
   logic battery_error_latch;
   logic supply_loss_flag;

   assign error_summary_flag_o = param_error_flag_i | syntax_error_flag_i |
      circuit_error_flag_i | operation_error_flag_i;
   assign battery_low_flag = battery_level_i < battery_threshold_reg;
   assign supply_loss_flag = |supply_fail_i;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         battery_error_latch <= 1'b0;
      end else if (battery_low_flag) begin
         battery_error_latch <= 1'b1;
      end else if (wr_clear && wdata_i[CL_BATT_LATCH]) begin
         battery_error_latch <= 1'b0;
      end
   end

   // The last unit number stays readable after the supply returns.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         supply_loss_unit_reg <= '0;
      end else if (supply_loss_flag) begin
         supply_loss_unit_reg <= lowest_set(supply_fail_i);
      end
   end

   // ****************************************************************
   // Arithmetic flags
   // ****************************************************************
   logic signed [16:0] sum_wide;
   logic signed [16:0] diff_wide;
   logic zero_result_flag;
   logic borrow_result_flag;
   logic carry_result_flag;

   assign sum_wide = {arith_a_i[15], arith_a_i} + {arith_b_i[15], arith_b_i};
   assign diff_wide = {arith_a_i[15], arith_a_i} - {arith_b_i[15], arith_b_i};

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         arith_result_o <= '0;
      end else if (arith_valid_i) begin
         unique case (pssf_op_t'(arith_op_i))
            PSSF_OP_ADD: arith_result_o <= sum_wide[15:0];
            PSSF_OP_SUB: arith_result_o <= diff_wide[15:0];
            PSSF_OP_SHL: arith_result_o <= {arith_a_i[14:0], 1'b0};
            PSSF_OP_SHR: arith_result_o <= {1'b0, arith_a_i[15:1]};
         endcase
      end
   end

   // Wrapped results compare to zero, as the stored value would.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         zero_result_flag <= 1'b0;
      end else if (to_stop) begin
         zero_result_flag <= 1'b0;
      end else if (arith_valid_i && arith_op_i == PSSF_OP_ADD) begin
         zero_result_flag <= sum_wide[15:0] == 16'h0000;
      end else if (arith_valid_i && arith_op_i == PSSF_OP_SUB) begin
         zero_result_flag <= diff_wide[15:0] == 16'h0000;
      end else if (wr_ctrl) begin
         zero_result_flag <= wdata_i[CT_ZERO];
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         borrow_result_flag <= 1'b0;
      end else if (to_stop) begin
         borrow_result_flag <= 1'b0;
      end else if (arith_valid_i && arith_op_i == PSSF_OP_SUB) begin
         borrow_result_flag <= diff_wide[16] != diff_wide[15] &&
            diff_wide[16];
      end else if (wr_ctrl) begin
         borrow_result_flag <= wdata_i[CT_BORROW];
      end
   end

   // Carry, like the zero and borrow flags, may also be preset by software.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         carry_result_flag <= 1'b0;
      end else if (to_stop) begin
         carry_result_flag <= 1'b0;
      end else if (arith_valid_i && arith_op_i == PSSF_OP_ADD) begin
         carry_result_flag <= sum_wide[16] != sum_wide[15] &&
            !sum_wide[16];
      end else if (arith_valid_i && arith_op_i == PSSF_OP_SHL) begin
         carry_result_flag <= arith_a_i[15];
      end else if (arith_valid_i && arith_op_i == PSSF_OP_SHR) begin
         carry_result_flag <= arith_a_i[0];
      end else if (wr_ctrl) begin
         carry_result_flag <= wdata_i[CT_CARRY];
      end
   end

   // ****************************************************************
   // Instruction completion and transfer interrupt permit
   // ****************************************************************
   logic instr_complete_flag;
   logic transfer_irq_permit;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         instr_complete_flag <= 1'b0;
      end else if (instr_done_i) begin
         instr_complete_flag <= 1'b1;
      end else if (to_stop || instr_start_i) begin
         instr_complete_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         transfer_irq_permit <= 1'b0;
      end else if (wr_ctrl) begin
         transfer_irq_permit <= wdata_i[CT_XFER_PERMIT];
      end
   end

   // Without permit a pending interrupt waits for the transfer to end.
   assign irq_service_o = irq_pending_i &&
      (!xfer_active_i || transfer_irq_permit);

   // ****************************************************************
   // Register read port
   // ****************************************************************
   logic [15:0] status_word;
   logic [15:0] ctrl_word;
   logic [15:0] next_rdata;

   always_comb begin
      status_word = '0;
      status_word[ST_RUN_NO] = run_monitor_no_o;
      status_word[ST_RUN_NC] = run_monitor_nc_o;
      status_word[ST_INIT_NO] = initial_pulse_no_o;
      status_word[ST_INIT_NC] = initial_pulse_nc_o;
      status_word[ST_ERR_SUM] = error_summary_flag_o;
      status_word[ST_BATT_LOW] = battery_low_flag;
      status_word[ST_BATT_LATCH] = battery_error_latch;
      status_word[ST_MOMENTARY] = momentary_outage_flag;
      status_word[ST_PF_DET] = power_fail_detected_flag;
      status_word[ST_SUPPLY] = supply_loss_flag;
      status_word[ST_P10MS] = pulse_10ms_o;
      status_word[ST_P100MS] = pulse_100ms_o;
      status_word[ST_P1S] = pulse_1s_o;
      status_word[ST_P1MIN] = pulse_1min_o;
      status_word[ST_RTC] = 1'b1;
      status_word[ST_INSTR_DONE] = instr_complete_flag;
   end

   always_comb begin
      ctrl_word = '0;
      ctrl_word[CT_XFER_PERMIT] = transfer_irq_permit;
      ctrl_word[CT_CARRY] = carry_result_flag;
      ctrl_word[CT_ZERO] = zero_result_flag;
      ctrl_word[CT_BORROW] = borrow_result_flag;
   end

   // Unmapped words read zero so unused positions stay inert.
   always_comb begin
      next_rdata = '0;
      unique case (addr_i)
         REG_STATUS: next_rdata = status_word;
         REG_CTRL: next_rdata = ctrl_word;
         REG_BATT_THR: next_rdata = battery_threshold_reg;
         REG_OUTAGE_ALLOW: next_rdata = outage_allow_time_reg;
         REG_LOSS_UNIT: next_rdata = supply_loss_unit_reg;
         REG_ARITH_RES: next_rdata = arith_result_o;
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= '0;
      end
   end

endmodule

// ===== logic/pssf_pkg.sv
// Constants shared by the special status flag bank.
package pssf_pkg;

   // ****************************************************************
   // Time base
   // ****************************************************************
   localparam int CLK_HZ = 50000000;
   localparam int MS_PER_S = 1000;
   localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
   localparam int HALF_10MS_MS = 5;
   localparam int HALF_100MS_MS = 50;
   localparam int HALF_1S_MS = 500;
   localparam int HALF_1MIN_S = 30;
   localparam int HALF_1MIN_MS = HALF_1MIN_S * MS_PER_S;

   // ****************************************************************
   // Register offsets (word index)
   // ****************************************************************
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h1;
   localparam logic [3:0] REG_CLEAR = 4'h2;
   localparam logic [3:0] REG_BATT_THR = 4'h3;
   localparam logic [3:0] REG_OUTAGE_ALLOW = 4'h4;
   localparam logic [3:0] REG_LOSS_UNIT = 4'h5;
   localparam logic [3:0] REG_ARITH_RES = 4'h6;

   // ****************************************************************
   // Status word bit positions
   // ****************************************************************
   localparam int ST_RUN_NO = 0;
   localparam int ST_RUN_NC = 1;
   localparam int ST_INIT_NO = 2;
   localparam int ST_INIT_NC = 3;
   localparam int ST_ERR_SUM = 4;
   localparam int ST_BATT_LOW = 5;
   localparam int ST_BATT_LATCH = 6;
   localparam int ST_MOMENTARY = 7;
   localparam int ST_PF_DET = 8;
   localparam int ST_SUPPLY = 9;
   localparam int ST_P10MS = 10;
   localparam int ST_P100MS = 11;
   localparam int ST_P1S = 12;
   localparam int ST_P1MIN = 13;
   localparam int ST_RTC = 14;
   localparam int ST_INSTR_DONE = 15;

   // Control, clear and arithmetic-flag positions.
   localparam int CT_XFER_PERMIT = 0;
   localparam int CT_CARRY = 1;
   localparam int CT_ZERO = 2;
   localparam int CT_BORROW = 3;
   localparam int CL_MOMENTARY = 0;
   localparam int CL_BATT_LATCH = 1;
   localparam int CL_PF_DET = 2;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] RST_BATT_THR = 16'h0bb8;
   localparam logic [15:0] RST_OUTAGE_ALLOW = 16'h000a;

   typedef enum logic [1:0] {
      PSSF_OP_ADD = 2'b00,
      PSSF_OP_SUB = 2'b01,
      PSSF_OP_SHL = 2'b10,
      PSSF_OP_SHR = 2'b11
   } pssf_op_t;

   typedef enum logic [1:0] {
      PSSF_STOP = 2'b00,
      PSSF_FIRST_SCAN = 2'b01,
      PSSF_RUN = 2'b10
   } pssf_mode_t;

endpackage

// ===== logic/pssf_pulse_gen.sv
// Square-wave generator stepped by the millisecond tick.
`timescale 1ns/1ps
module pssf_pulse_gen #(
   parameter int HALF_TICKS = 5
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic tick_i,
   output logic pulse_o
);
   localparam int CW = $clog2(HALF_TICKS + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF_TICKS - 1);

   logic [CW-1:0] count;

   // Equal halves come from toggling after every HALF_TICKS ticks.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count <= '0;
         pulse_o <= 1'b0;
      end else if (tick_i) begin
         if (count == LAST) begin
            count <= '0;
            pulse_o <= ~pulse_o;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule

// ===== tb/pssf_flags_monitor.sv
// Port-level assertions for the special status flag bank.
`timescale 1ns/1ps
module pssf_flags_monitor
   import pssf_pkg::*;
#(
   parameter int TICK_CYC = 4,
   parameter int H10MS = 2
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic run_switch_i,
   input wire logic scan_end_i,
   input wire logic param_error_flag_i,
   input wire logic syntax_error_flag_i,
   input wire logic circuit_error_flag_i,
   input wire logic operation_error_flag_i,
   input wire logic arith_valid_i,
   input wire logic [1:0] arith_op_i,
   input wire logic [15:0] arith_a_i,
   input wire logic [15:0] arith_b_i,
   input wire logic xfer_active_i,
   input wire logic irq_pending_i,
   input wire logic irq_service_o,
   input wire logic run_monitor_no_o,
   input wire logic run_monitor_nc_o,
   input wire logic initial_pulse_no_o,
   input wire logic initial_pulse_nc_o,
   input wire logic error_summary_flag_o,
   input wire logic pulse_10ms_o,
   input wire logic [15:0] arith_result_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   // ****************************************************************
   // Half-period counter
   // ****************************************************************
   // The first segment after reset is skipped, since it is counted from reset and runs one cycle longer.
   int cnt;
   logic prev;
   logic seen;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= 0;
         prev <= 1'b0;
         seen <= 1'b0;
      end else begin
         prev <= pulse_10ms_o;
         seen <= seen | (pulse_10ms_o != prev);
         cnt <= (pulse_10ms_o != prev) ? 0 : cnt + 1;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   run_nc_a: assert property (run_monitor_nc_o == !run_monitor_no_o)
      else $error("run monitor pair not inverse");
   init_nc_a: assert property (initial_pulse_nc_o != initial_pulse_no_o)
      else $error("initial pulse pair not inverse");
   err_sum_a: assert property (error_summary_flag_o ==
      (param_error_flag_i | syntax_error_flag_i | circuit_error_flag_i |
      operation_error_flag_i))
      else $error("error summary wrong");
   irq_free_a: assert property (irq_pending_i && !xfer_active_i |->
      irq_service_o)
      else $error("interrupt not serviced outside transfer");
   irq_none_a: assert property (!irq_pending_i |-> !irq_service_o)
      else $error("service without pending interrupt");
   run_stop_a: assert property (!run_switch_i |=> !run_monitor_no_o)
      else $error("run monitor high after stop");
   init_once_a: assert property (initial_pulse_no_o && scan_end_i |=>
      !initial_pulse_no_o)
      else $error("initial pulse longer than one scan");
   add_res_a: assert property (arith_valid_i &&
      arith_op_i == PSSF_OP_ADD |=>
      arith_result_o == 16'($past(arith_a_i) + $past(arith_b_i)))
      else $error("addition result wrong");
   p10_half_a: assert property (seen && pulse_10ms_o != prev |->
      cnt == H10MS * TICK_CYC - 1)
      else $error("fast clock half period wrong");

   cover property ($rose(run_monitor_no_o));
   cover property ($fell(initial_pulse_no_o));
   cover property (arith_valid_i && arith_op_i == PSSF_OP_SUB);
endmodule

bind pssf_flags pssf_flags_monitor #(.TICK_CYC(TICK_CYC), .H10MS(H10MS))
   u_mon (.*);

// ===== tb/pssf_flags_tb.sv
// Register-port testbench for the special status flag bank.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module pssf_flags_tb;
   import pssf_pkg::*;
   localparam int TC = 4;
   localparam int HS [4] = '{2, 3, 5, 6};
   logic clk_i, resetn_i, wr_i, rd_i, run_switch_i, scan_end_i, power_ok_i;
   logic arith_valid_i, instr_start_i, instr_done_i, xfer_active_i;
   logic irq_pending_i, irq_service_o, run_monitor_no_o, run_monitor_nc_o;
   logic initial_pulse_no_o, initial_pulse_nc_o, error_summary_flag_o;
   logic pulse_10ms_o, pulse_100ms_o, pulse_1s_o, pulse_1min_o;
   wire logic param_error_flag_i, syntax_error_flag_i;
   wire logic circuit_error_flag_i, operation_error_flag_i;
   logic [3:0] addr_i, errv, pv;
   logic [15:0] wdata_i, rdata_o, battery_level_i, arith_a_i, arith_b_i, d;
   logic [15:0] arith_result_o;
   logic [7:0] supply_fail_i;
   logic [1:0] arith_op_i;
   logic [15:0] ta [5] = '{16'h7fff, 16'h8000, 16'h0005, 16'h8001, 16'h0001};
   logic [15:0] tr [5] = '{16'h8000, 16'h7fff, 16'h0000, 16'h0002, 16'h0000};
   logic [15:0] tf [5] = '{16'h0002, 16'h0008, 16'h0004, 16'h0002, 16'h0002};
   logic [15:0] tb [5] = '{16'h0001, 16'h0001, 16'h0005, 16'h0001, 16'h0001};
   logic [1:0] to [5] = '{PSSF_OP_ADD, PSSF_OP_SUB, PSSF_OP_SUB, PSSF_OP_SHL,
      PSSF_OP_SHR};
   int err_count = 0;
   int n_tests = 0;

   assign {param_error_flag_i, syntax_error_flag_i, circuit_error_flag_i,
      operation_error_flag_i} = errv;
   assign pv = {pulse_1min_o, pulse_1s_o, pulse_100ms_o, pulse_10ms_o};

   pssf_flags #(.TICK_CYC(TC), .H10MS(2), .H100MS(3), .H1S(5), .H1MIN(6))
      dut (.*);

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // ****************************************************************
   // Bus and wait tasks
   // ****************************************************************
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rc(input string s, input logic [3:0] a,
      input logic [15:0] m, input logic [15:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o & m;
      `CHK(s, e, d)
   endtask

   // Counts cycles while a clock flag stays at lvl; a stuck flag ends the run.
   task automatic hold(input int i, input logic lvl, output int n);
      n = 0;
      while (pv[i] === lvl && n < 200) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (n >= 200) begin
         err_count++;
         report_and_stop();
      end
   endtask

   initial begin
      int n;
      {resetn_i, wr_i, rd_i, run_switch_i, scan_end_i, arith_valid_i} = '0;
      {instr_start_i, instr_done_i, xfer_active_i, irq_pending_i} = '0;
      {addr_i, wdata_i, errv, supply_fail_i, arith_op_i} = '0;
      {battery_level_i, arith_a_i, arith_b_i} = '0;
      power_ok_i = 1'b1;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      rc("thr", REG_BATT_THR, 16'hffff, RST_BATT_THR);
      rc("allow", REG_OUTAGE_ALLOW, 16'hffff, RST_OUTAGE_ALLOW);
      rc("idle", REG_STATUS, 16'h400f, 16'h400a);
      wr(REG_STATUS, 16'h0000);
      rc("ro", REG_STATUS, 16'h4000, 16'h4000);
      wr(REG_ARITH_RES, 16'hffff);
      rc("res", REG_ARITH_RES, 16'hffff, 16'h0000);
      rc("hole", 4'hf, 16'hffff, 16'h0000);
      wr(REG_BATT_THR, 16'h0100);
      @(posedge clk_i) battery_level_i <= 16'h00ff;
      rc("blow", REG_STATUS, 16'h0060, 16'h0060);
      @(posedge clk_i) battery_level_i <= 16'h0100;
      rc("bok", REG_STATUS, 16'h0060, 16'h0040);
      wr(REG_CLEAR, 16'h0002);
      rc("bclr", REG_STATUS, 16'h0040, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i) errv <= 4'(1) << i;
         rc("err", REG_STATUS, 16'h0010, 16'h0010);
      end
      @(posedge clk_i) errv <= 4'h0;
      rc("noerr", REG_STATUS, 16'h0010, 16'h0000);
      @(posedge clk_i) supply_fail_i <= 8'h28;
      rc("loss", REG_STATUS, 16'h0200, 16'h0200);
      rc("unit", REG_LOSS_UNIT, 16'hffff, 16'h0003);
      @(posedge clk_i) run_switch_i <= 1'b1;
      @(posedge clk_i);
      #1 `CHK("run", 2'b11, {run_monitor_no_o, initial_pulse_no_o})
      @(posedge clk_i) scan_end_i <= 1'b1;
      @(posedge clk_i) scan_end_i <= 1'b0;
      #1 `CHK("scan", 2'b10, {run_monitor_no_o, initial_pulse_no_o})
      for (int i = 0; i < 5; i++) begin
         wr(REG_CTRL, 16'h0000);
         @(posedge clk_i);
         arith_valid_i <= 1'b1;
         arith_op_i <= to[i];
         arith_a_i <= ta[i];
         arith_b_i <= tb[i];
         @(posedge clk_i) arith_valid_i <= 1'b0;
         rc("flags", REG_CTRL, 16'h000e, tf[i]);
         `CHK("result", tr[i], arith_result_o)
      end
      @(posedge clk_i) instr_done_i <= 1'b1;
      @(posedge clk_i) instr_done_i <= 1'b0;
      rc("done", REG_STATUS, 16'h8000, 16'h8000);
      @(posedge clk_i) instr_start_i <= 1'b1;
      @(posedge clk_i) instr_start_i <= 1'b0;
      rc("start", REG_STATUS, 16'h8000, 16'h0000);
      wr(REG_CTRL, 16'h0003);
      @(posedge clk_i) {xfer_active_i, irq_pending_i, instr_done_i} <= 3'b111;
      #1 `CHK("irq", 1'b1, irq_service_o)
      wr(REG_CTRL, 16'h0002);
      #1 `CHK("irqoff", 1'b0, irq_service_o)
      @(posedge clk_i) {run_switch_i, xfer_active_i, instr_done_i} <= 3'b000;
      rc("stop", REG_STATUS, 16'h8001, 16'h0000);
      rc("stopc", REG_CTRL, 16'h000e, 16'h0000);
      @(posedge clk_i) run_switch_i <= 1'b1;
      @(posedge clk_i) power_ok_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      power_ok_i <= 1'b1;
      rc("brief", REG_STATUS, 16'h0181, 16'h0181);
      wr(REG_CLEAR, 16'h0005);
      wr(REG_OUTAGE_ALLOW, 16'h0002);
      rc("clr", REG_STATUS, 16'h0180, 16'h0000);
      @(posedge clk_i) power_ok_i <= 1'b0;
      repeat (24) @(posedge clk_i);
      power_ok_i <= 1'b1;
      rc("long", REG_STATUS, 16'h0181, 16'h0080);
      for (int i = 0; i < 4; i++) begin
         hold(i, 1'b1, n);
         hold(i, 1'b0, n);
         hold(i, 1'b1, n);
         `CHK("half", HS[i] * TC, n)
      end
      report_and_stop();
   end
endmodule
